// ===== wwd_timer.sv
// window watchdog timer: control, lock, crossing and counter
`default_nettype none
// Operation
// - enabled counter resets the system if not cleared before time-out
// - counter advances on rising edges of the 1.024 kHz slow tick clock
// - eleven period codes give 8 ms up to 8 s
// - non-zero period field enables; zero keeps it off
// - non-zero window field selects window mode
// - zero window field means normal single-period mode
// - each clear restarts a full time-out period
// - window mode: clear too early or too late resets the system
// - counting is independent of sleep and of the main clock source
// - control and lock writes need the change guard sequence
// - control resets from boot fuse; fuse enable sets lock
// - control writes reach the counter only after slow tick crossing
// - closed period precedes open; first closed period starts after first clear
// - pending flag during control crossing; processor waits for it
// - lock blocks control writes, is set-only, cleared only in debug
// - clear crossing takes slow ticks; clears during crossing are ignored
module wwd_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // slow clock and boot configuration
  input  wire logic       slow_tick_clock,
  input  wire logic [7:0] boot_fuse_config,
  // processor writes
  input  wire logic       ctrl_wr,
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       lock_wr,
  input  wire logic       change_guard_ok,
  input  wire logic       debug_mode,
  input  wire logic       watchdog_clear_instr,
  // status
  output logic [7:0]      primary_control,
  output logic            lock,
  output logic            crossing_pending,
  output logic            clear_pending,
  output logic            system_reset
);
  typedef wwd_pkg::wwd_state_t wwd_state_t;

  // slow clock synchroniser; first stage feeds only the second
  logic slow_s1_reg, slow_s2_reg, slow_s3_reg;
  logic tick;
  always_ff @(posedge clk) begin
    if (srst) begin
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
      slow_s3_reg <= 1'b0;
    end else begin
      slow_s1_reg <= slow_tick_clock;
      slow_s2_reg <= slow_s1_reg;
      slow_s3_reg <= slow_s2_reg;
    end
  end
  assign tick = slow_s2_reg & ~slow_s3_reg;

  // processor side control and lock
  logic       boot_done_reg, boot_done_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic       lock_reg, lock_next;
  logic       cfg_req, cfg_done, cfg_busy;
  logic       clr_req, clr_done, clr_busy;

  assign cfg_req = boot_done_reg & ctrl_wr & change_guard_ok & ~lock_reg & ~cfg_busy;
  assign clr_req = boot_done_reg & watchdog_clear_instr & ~clr_busy;

  // fuse load happens on the first edge after reset release, never under reset
  always_comb begin
    boot_done_next = 1'b1;
    ctrl_next      = ctrl_reg;
    lock_next      = lock_reg;
    if (!boot_done_reg) begin
      ctrl_next = boot_fuse_config;
      lock_next = (boot_fuse_config[wwd_pkg::PERIOD_LSB +: wwd_pkg::FIELD_W] != wwd_pkg::SEL_OFF);
    end else begin
      if (cfg_req) begin
        ctrl_next = ctrl_wdata;
      end
      if (debug_mode) begin
        lock_next = 1'b0;
      end
      if (lock_wr && change_guard_ok) begin
        lock_next = 1'b1; // set wins over the debug clear
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_done_reg <= 1'b0;
      ctrl_reg      <= wwd_pkg::CTRL_RST;
      lock_reg      <= 1'b0;
    end else begin
      boot_done_reg <= boot_done_next;
      ctrl_reg      <= ctrl_next;
      lock_reg      <= lock_next;
    end
  end

  // crossings into the slow tick domain
  wwd_tick_sync #(.STAGES(wwd_pkg::SYNC_TICKS)) u_cfg_sync (
    .clk  (clk),
    .srst (srst),
    .req  (cfg_req),
    .busy (cfg_busy),
    .tick (tick),
    .done (cfg_done)
  );

  wwd_tick_sync #(.STAGES(wwd_pkg::SYNC_TICKS)) u_clr_sync (
    .clk  (clk),
    .srst (srst),
    .req  (clr_req),
    .busy (clr_busy),
    .tick (tick),
    .done (clr_done)
  );

  // slow side: settings in use, counter and mode state
  logic [3:0]                 act_period_reg, act_period_next;
  logic [3:0]                 act_window_reg, act_window_next;
  logic [wwd_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  wwd_state_t                 state_reg, state_next;
  logic                       rst_reg, rst_next;
  logic                       boot_apply;
  logic [wwd_pkg::CNT_W-1:0]  cnt_inc, open_len, closed_len;

  assign boot_apply = ~boot_done_reg;
  assign cnt_inc    = cnt_reg + 14'h0001;
  assign open_len   = wwd_pkg::sel_ticks(act_period_reg);
  assign closed_len = wwd_pkg::sel_ticks(act_window_reg);

  // the boot fuse applies at once; later writes only after the crossing completes
  always_comb begin
    act_period_next = act_period_reg;
    act_window_next = act_window_reg;
    cnt_next        = cnt_reg;
    state_next      = state_reg;
    rst_next        = 1'b0;
    if (boot_apply) begin
      act_period_next = boot_fuse_config[wwd_pkg::PERIOD_LSB +: wwd_pkg::FIELD_W];
      act_window_next = boot_fuse_config[wwd_pkg::WINDOW_LSB +: wwd_pkg::FIELD_W];
    end else if (cfg_done) begin
      act_period_next = ctrl_reg[wwd_pkg::PERIOD_LSB +: wwd_pkg::FIELD_W];
      act_window_next = ctrl_reg[wwd_pkg::WINDOW_LSB +: wwd_pkg::FIELD_W];
    end
    case (state_reg)
      wwd_pkg::ST_OFF: begin
        cnt_next = '0;
        if (act_period_reg != wwd_pkg::SEL_OFF) begin
          state_next = wwd_pkg::ST_OPEN; // first period is open, closed waits for a clear
        end
      end
      wwd_pkg::ST_CLOSED: begin
        if (clr_done) begin
          rst_next   = 1'b1; // too early
          cnt_next   = '0;
          state_next = wwd_pkg::ST_OPEN;
        end else if (tick) begin
          if (cnt_inc >= closed_len) begin
            cnt_next   = '0;
            state_next = wwd_pkg::ST_OPEN;
          end else begin
            cnt_next = cnt_inc;
          end
        end
      end
      default: begin
        if (clr_done) begin
          cnt_next   = '0;
          state_next = (act_window_reg != wwd_pkg::SEL_OFF) ? wwd_pkg::ST_CLOSED : wwd_pkg::ST_OPEN;
        end else if (tick) begin
          if (cnt_inc >= open_len) begin
            rst_next = 1'b1; // time-out
            cnt_next = '0;
          end else begin
            cnt_next = cnt_inc;
          end
        end
      end
    endcase
    // halting in debug restarts the counter and skips the first closed period
    if (debug_mode && state_reg != wwd_pkg::ST_OFF) begin
      cnt_next   = '0;
      state_next = wwd_pkg::ST_OPEN;
      rst_next   = 1'b0;
    end
    if (act_period_reg == wwd_pkg::SEL_OFF) begin
      state_next = wwd_pkg::ST_OFF;
      rst_next   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      act_period_reg <= wwd_pkg::SEL_OFF;
      act_window_reg <= wwd_pkg::SEL_OFF;
      cnt_reg        <= '0;
      state_reg      <= wwd_pkg::ST_OFF;
      rst_reg        <= 1'b0;
    end else begin
      act_period_reg <= act_period_next;
      act_window_reg <= act_window_next;
      cnt_reg        <= cnt_next;
      state_reg      <= state_next;
      rst_reg        <= rst_next;
    end
  end

  // outputs straight from flip-flops
  assign primary_control  = ctrl_reg;
  assign lock             = lock_reg;
  assign crossing_pending = cfg_busy;
  assign clear_pending    = clr_busy;
  assign system_reset     = rst_reg;

  a_timeout_fires: assert property (@(posedge clk) disable iff (srst)
    (state_reg == wwd_pkg::ST_OPEN && tick && !clr_done && !debug_mode && act_period_reg != 4'h0
     && cnt_inc >= open_len) |=> system_reset) else $error("time-out did not reset");
  a_early_clear: assert property (@(posedge clk) disable iff (srst)
    (state_reg == wwd_pkg::ST_CLOSED && clr_done && !debug_mode && act_period_reg != 4'h0)
    |=> system_reset) else $error("early clear did not reset");
  a_clear_restart: assert property (@(posedge clk) disable iff (srst)
    (state_reg == wwd_pkg::ST_OPEN && clr_done && act_period_reg != 4'h0)
    |=> (cnt_reg == '0 && !system_reset)) else $error("clear did not restart");
  a_window_entry: assert property (@(posedge clk) disable iff (srst)
    (state_reg == wwd_pkg::ST_OPEN && clr_done && !debug_mode && act_period_reg != 4'h0
     && act_window_reg != 4'h0) |=> state_reg == wwd_pkg::ST_CLOSED) else $error("window not entered");
  a_off_quiet: assert property (@(posedge clk) disable iff (srst)
    (act_period_reg == 4'h0) |=> (state_reg == wwd_pkg::ST_OFF && !system_reset)) else $error("off but active");
  a_lock_blocks: assert property (@(posedge clk) disable iff (srst)
    (boot_done_reg && lock_reg) |=> $stable(primary_control)) else $error("locked control changed");
  a_lock_sticky: assert property (@(posedge clk) disable iff (srst)
    (lock_reg && !debug_mode) |=> lock_reg) else $error("lock cleared outside debug");
  a_guard_needed: assert property (@(posedge clk) disable iff (srst)
    (boot_done_reg && !change_guard_ok) |=> ($stable(primary_control) && ($past(lock_reg) || !lock_reg)))
    else $error("unguarded write took effect");
  a_boot_lock: assert property (@(posedge clk) disable iff (srst)
    (!boot_done_reg && boot_fuse_config[3:0] != 4'h0) |=> (lock && primary_control == $past(boot_fuse_config)))
    else $error("fuse enable did not lock");
  a_write_pending: assert property (@(posedge clk) disable iff (srst)
    cfg_req |=> crossing_pending ##1 (crossing_pending && act_period_reg == $past(act_period_reg)))
    else $error("write not held for crossing");
  a_clear_ignored: assert property (@(posedge clk) disable iff (srst)
    (clear_pending && watchdog_clear_instr && !tick) |=> clear_pending) else $error("clear crossing cut short");
endmodule : wwd_timer
`default_nettype wire

// ===== wwd_pkg.sv
// shared constants and types for the window watchdog timer
`default_nettype none
package wwd_pkg;
  // primary control field layout and reset value
  localparam int            FIELD_W      = 4;
  localparam int            PERIOD_LSB   = 0;
  localparam int            WINDOW_LSB   = 4;
  localparam logic [7:0]    CTRL_RST     = 8'h00;
  localparam logic [3:0]    SEL_OFF      = 4'h0;
  localparam logic [3:0]    SEL_MAX      = 4'hB;
  // slow tick timing: 1.024 kHz, shortest period is 8 ticks (8 ms)
  localparam int            SLOW_TICK_HZ = 1024;
  localparam int            CNT_W        = 14;
  localparam logic [13:0]   BASE_TICKS   = 14'h0008;
  localparam int            SYNC_TICKS   = 2;

  // counter state, one-hot
  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_OPEN   = 3'b010,
    ST_CLOSED = 3'b100
  } wwd_state_t;

  // selection code to length in slow ticks; reserved codes clamp to the longest
  function automatic logic [13:0] sel_ticks(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    if (s == SEL_OFF) begin
      sel_ticks = BASE_TICKS;
    end else begin
      sel_ticks = BASE_TICKS << (s - 4'h1);
    end
  endfunction : sel_ticks
endpackage : wwd_pkg
`default_nettype wire

// ===== wwd_tick_sync.sv
// request crossing into the slow tick domain: busy until a number of tick edges pass
`default_nettype none
module wwd_tick_sync #(
  parameter int STAGES = wwd_pkg::SYNC_TICKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // request side
  input  wire logic req,
  output logic      busy,
  // slow tick side
  input  wire logic tick,
  output logic      done
);
  logic       busy_reg, busy_next;
  logic       done_reg, done_next;
  logic [1:0] cnt_reg, cnt_next;

  // requests while busy are dropped, so one request gives exactly one done pulse
  always_comb begin
    busy_next = busy_reg;
    done_next = 1'b0;
    cnt_next  = cnt_reg;
    if (busy_reg) begin
      if (tick) begin
        if (cnt_reg == 2'(STAGES - 1)) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          cnt_next  = 2'h0;
        end else begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
    end else if (req) begin
      busy_next = 1'b1;
      cnt_next  = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg  <= 2'h0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

  a_done_after_busy: assert property (@(posedge clk) disable iff (srst)
    done |-> $past(busy_reg)) else $error("done without pending request");
endmodule : wwd_tick_sync
`default_nettype wire

// ===== wwd_cpu_model.sv
// processor core model: guarded control and lock writes, clear requests
`default_nettype none
module wwd_cpu_model (
  // clock
  input  wire logic       clk,
  // watchdog status
  input  wire logic       crossing_pending,
  // request lines
  output logic            ctrl_wr,
  output logic [7:0]      ctrl_wdata,
  output logic            lock_wr,
  output logic            change_guard_ok,
  output logic            watchdog_clear_instr
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle lines at time zero
  initial begin
    ctrl_wr              = 1'b0;
    ctrl_wdata           = 8'h00;
    lock_wr              = 1'b0;
    change_guard_ok      = 1'b0;
    watchdog_clear_instr = 1'b0;
  end

  // control write; g low stands for a skipped guard sequence
  task automatic ctrl_write(input logic [7:0] d, input logic g, output bit ok);
    int n;
    @(negedge clk);
    for (n = 0; n < 80 && crossing_pending !== 1'b0; n++) @(negedge clk);
    ok              = (n < 80);
    ctrl_wr         = 1'b1;
    ctrl_wdata      = d;
    change_guard_ok = g;
    @(negedge clk);
    ctrl_wr         = 1'b0;
    change_guard_ok = 1'b0;
    ctrl_wdata      = ~d; // stale data once the strobe drops
  endtask : ctrl_write

  // lock write, set-only on the device side
  task automatic lock_write(input logic g);
    @(negedge clk);
    lock_wr         = 1'b1;
    change_guard_ok = g;
    @(negedge clk);
    lock_wr         = 1'b0;
    change_guard_ok = 1'b0;
  endtask : lock_write

  // one clear instruction, a single-cycle pulse
  task automatic clear_instr();
    @(negedge clk);
    watchdog_clear_instr = 1'b1;
    @(negedge clk);
    watchdog_clear_instr = 1'b0;
  endtask : clear_instr
endmodule : wwd_cpu_model
`default_nettype wire

// ===== window_watchdog_timer_tb.sv
// self-checking bench for the window watchdog timer
`default_nettype none
module window_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // design connections
  logic       clk;
  logic       srst;
  logic       slow_tick_clock;
  logic       debug_mode;
  logic [7:0] boot_fuse_config;
  logic       ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic       lock_wr;
  logic       change_guard_ok;
  logic       watchdog_clear_instr;
  logic [7:0] primary_control;
  logic       lock;
  logic       crossing_pending;
  logic       clear_pending;
  logic       system_reset;
  // bench state
  int         err_total;
  int         n_checks;
  int         seed;
  int         cyc;
  int         t;
  bit         ok;
  logic [3:0] code;

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // slow tick sped up to 8 system clocks so that periods fit the run; odd phase
  initial begin
    slow_tick_clock = 1'b0;
    #7;
    forever #160 slow_tick_clock = ~slow_tick_clock;
  end

  wwd_timer dut_u (
    .clk(clk), .srst(srst), .slow_tick_clock(slow_tick_clock), .boot_fuse_config(boot_fuse_config),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .lock_wr(lock_wr), .change_guard_ok(change_guard_ok),
    .debug_mode(debug_mode), .watchdog_clear_instr(watchdog_clear_instr), .primary_control(primary_control),
    .lock(lock), .crossing_pending(crossing_pending), .clear_pending(clear_pending),
    .system_reset(system_reset)
  );
  wwd_cpu_model cpu_u (
    .clk(clk), .crossing_pending(crossing_pending), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .lock_wr(lock_wr), .change_guard_ok(change_guard_ok), .watchdog_clear_instr(watchdog_clear_instr)
  );

  // expected period in system clocks; reserved codes clamp to the longest
  function automatic int exp_cycles(input logic [3:0] c);
    logic [3:0] s;
    s = (c > 4'hB) ? 4'hB : c;
    return (8 << (s - 4'h1)) * 8;
  endfunction : exp_cycles

  task automatic check(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // reset held 16 cycles, then the fuse value must be loaded
  task automatic do_reset(input logic [7:0] fuse);
    srst             = 1'b1;
    boot_fuse_config = fuse;
    repeat (16) @(negedge clk);
    check({primary_control, lock, crossing_pending, clear_pending, system_reset} === 12'h000, "reset values");
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check(primary_control === fuse && lock === (fuse[3:0] != 4'h0), "boot load");
  endtask : do_reset

  // bounded wait until both crossings are idle
  task automatic wait_idle();
    for (cyc = 0; cyc < 80 && (crossing_pending !== 1'b0 || clear_pending !== 1'b0); cyc++) @(negedge clk);
    check(cyc < 80, "crossing stuck");
    if (cyc >= 80) print_verdict();
  endtask : wait_idle

  // reset pulse must appear within [lo, hi] cycles from now
  task automatic expect_rst(input int lo, input int hi);
    for (cyc = 0; cyc <= hi && system_reset !== 1'b1; cyc++) @(negedge clk);
    check(cyc >= lo && cyc <= hi, "reset timing");
    if (cyc > hi) print_verdict();
  endtask : expect_rst

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(negedge clk);
      if (system_reset !== 1'b0) hits++;
    end
    check(hits == 0, "reset while off");
  endtask : quiet

  // disable first so the counter starts from a known point
  task automatic enable(input logic [7:0] d);
    cpu_u.ctrl_write(8'h00, 1'b1, ok);
    cpu_u.ctrl_write(d, 1'b1, ok);
    check(ok && primary_control === d && crossing_pending === 1'b1, "write accept");
    // a pending flag that never dropped is a hang: report at once
    if (!ok) print_verdict();
    wait_idle();
  endtask : enable

  // main sequence
  initial begin
    err_total  = 0;
    n_checks   = 0;
    seed       = 6;
    debug_mode = 1'b0;
    do_reset(8'h00);
    cpu_u.ctrl_write(8'h01, 1'b0, ok);
    @(negedge clk);
    check(primary_control === 8'h00 && crossing_pending === 1'b0, "unguarded write");
    quiet(300);
    repeat (3) begin
      code = 4'(1 + ($unsigned($random(seed)) % 3));
      enable({4'h0, code});
      t = exp_cycles(code);
      expect_rst(t - 10, t + 10);
      repeat (t / 2) @(negedge clk);
      cpu_u.clear_instr();
      check(clear_pending === 1'b1, "clear not pending");
      cpu_u.clear_instr();
      wait_idle();
      expect_rst(t - 10, t + 10);
    end
    // window mode: early clear, then a clear inside the open slot
    enable(8'h12);
    repeat (20) @(negedge clk);
    cpu_u.clear_instr();
    wait_idle();
    cpu_u.clear_instr();
    expect_rst(0, 40);
    cpu_u.clear_instr();
    wait_idle();
    repeat (80) @(negedge clk);
    cpu_u.clear_instr();
    wait_idle();
    expect_rst(182, 202);
    cpu_u.lock_write(1'b0);
    check(lock === 1'b0, "unguarded lock");
    // fuse-enabled boot locks the control register
    do_reset(8'h02);
    expect_rst(110, 140);
    cpu_u.ctrl_write(8'h00, 1'b1, ok);
    @(negedge clk);
    check(primary_control === 8'h02 && crossing_pending === 1'b0, "locked write");
    debug_mode = 1'b1;
    repeat (2) @(negedge clk);
    check(lock === 1'b0, "debug unlock");
    debug_mode = 1'b0;
    cpu_u.lock_write(1'b1);
    check(lock === 1'b1, "lock set");
    print_verdict();
  end
endmodule : window_watchdog_timer_tb
`default_nettype wire
